// *** core/pidma_pkg.sv ***
package pidma_pkg;

	// Input FIFO entry: byte, marker and fault captured together.
	localparam int unsigned ENT_W         = 10;
	localparam int unsigned ENT_DATA_LSB  = 0;
	localparam int unsigned ENT_MARK_BIT  = 8;
	localparam int unsigned ENT_FAULT_BIT = 9;

	// Input FIFO: 24 usable places inside 32 storage slots.
	localparam int unsigned   IN_PTR_W = 6;
	localparam int unsigned   IN_SLOTS = 32;
	localparam logic [5:0]    IN_DEPTH = 6'h18;

	// Memory side.
	localparam int unsigned ADDR_W     = 32;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned BE_W       = 4;
	localparam int unsigned LEN_W      = 16;
	localparam int unsigned WF_DEPTH   = 4;
	localparam int unsigned WF_W       = BE_W + ADDR_W + DATA_W;
	localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
	localparam logic [1:0]  LAST_LANE  = 2'h3;
	localparam logic [3:0]  BE_NONE    = 4'h0;
	localparam logic [3:0]  BE_LANE0   = 4'h1;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_HUNT  = 3'b001,
		ST_XFER  = 3'b010,
		ST_DRAIN = 3'b011
	} pidma_state_e;

	function automatic logic [IN_PTR_W-1:0] gray2bin(
		input logic [IN_PTR_W-1:0] g
	);
		logic [IN_PTR_W-1:0] b;
		b[IN_PTR_W-1] = g[IN_PTR_W-1];
		for (int i = IN_PTR_W - 2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction : gray2bin

	function automatic logic [IN_PTR_W-1:0] bin2gray(
		input logic [IN_PTR_W-1:0] b
	);
		return b ^ (b >> 1);
	endfunction : bin2gray

endpackage : pidma_pkg

// *** core/pidma_top.sv ***
// Summary of operation
// - Receive one byte per transfer, never transmit.
// - Link inputs sampled on byte clock rising.
// - Valid bytes push into 24-entry input FIFO.
// - Full input FIFO silently drops the byte.
// - Channel input supplies buffer address and length.
// - Discard entries until marker rising edge found.
// - Forward from start byte until count reached.
// - Marker already high at issue needs fresh edge.
// - Write complete 32-bit words, advancing the address.
// - Flush leftovers as a final partial word.
// - Acknowledge only after all data written.
// - Fault in transfer discards write FIFO contents.
// - Fault restores address and count, silently rehunts.
// - Fault ignored while marker is low.
// - Fault on start byte skips that packet.
`timescale 1ns/1ps
`default_nettype none
module pidma_top #(
	parameter int unsigned LEN_W = pidma_pkg::LEN_W
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          link_byte_clock_i,
	input  wire logic                          link_byte_valid_i,
	input  wire logic [7:0]                    link_byte_bus_i,
	input  wire logic                          link_packet_fault_i,
	input  wire logic                          link_packet_marker_i,
	input  wire logic                          chan_req_i,
	input  wire logic [pidma_pkg::ADDR_W-1:0]  chan_addr_i,
	input  wire logic [LEN_W-1:0]              chan_len_i,
	output logic                               chan_ack_o,
	output logic                               chan_busy_o,
	output logic                               mem_valid_o,
	input  wire logic                          mem_ready_i,
	output logic [pidma_pkg::ADDR_W-1:0]       mem_addr_o,
	output logic [pidma_pkg::DATA_W-1:0]       mem_data_o,
	output logic [pidma_pkg::BE_W-1:0]         mem_be_o
);
	localparam int unsigned PW = pidma_pkg::IN_PTR_W;
	localparam int unsigned EW = pidma_pkg::ENT_W;
	localparam int unsigned SW = pidma_pkg::IN_SLOTS;

	// Link-domain state: entry storage, write pointer, read pointer sync.
	typedef struct packed {
		logic [SW-1:0][EW-1:0] mem;
		logic [PW-1:0]         wbin;
		logic [PW-1:0]         wgray;
		logic [PW-1:0]         rsync1;
		logic [PW-1:0]         rsync2;
	} pidma_lnk_s;

	// System-domain state.
	typedef struct packed {
		pidma_pkg::pidma_state_e        st;
		logic [PW-1:0]                  wsync1;
		logic [PW-1:0]                  wsync2;
		logic [PW-1:0]                  rbin;
		logic [PW-1:0]                  rgray;
		logic                           last_mark;
		logic [pidma_pkg::ADDR_W-1:0]   base;
		logic [LEN_W-1:0]               len;
		logic [pidma_pkg::ADDR_W-1:0]   addr;
		logic [LEN_W-1:0]               left;
		logic [1:0]                     lane;
		logic [pidma_pkg::DATA_W-1:0]   word;
		logic [pidma_pkg::BE_W-1:0]     be;
		logic                           ack;
	} pidma_sys_s;

	pidma_lnk_s lk_q;
	pidma_lnk_s lk_d;
	pidma_sys_s sq;
	pidma_sys_s sd;

	pidma_wf_if #(.W(pidma_pkg::WF_W)) wf ();

	pidma_word_fifo #(
		.W     (pidma_pkg::WF_W),
		.DEPTH (pidma_pkg::WF_DEPTH)
	) u_word_fifo (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.wf      (wf)
	);

	logic [PW-1:0]               lk_occ;
	logic                        lk_full;
	logic                        lk_push;
	logic                        avail;
	logic [EW-1:0]               head;
	logic                        h_mark;
	logic                        h_fault;
	logic [7:0]                  h_byte;
	logic                        rising;
	logic                        pop;
	logic                        take;
	logic                        err;
	logic                        push_v;
	logic [pidma_pkg::WF_W-1:0]  push_d;
	logic                        flush;
	logic [pidma_pkg::DATA_W-1:0] nword;
	logic [pidma_pkg::BE_W-1:0]  nbe;

	// Link domain. Inputs are synchronous to the byte clock, so they are
	// captured directly on its rising edge with no resynchronising.
	assign lk_occ  = lk_q.wbin - pidma_pkg::gray2bin(lk_q.rsync2);
	assign lk_full = (lk_occ >= pidma_pkg::IN_DEPTH);
	assign lk_push = link_byte_valid_i & ~lk_full;

	always_comb
	begin
		lk_d        = lk_q;
		lk_d.rsync1 = sq.rgray;
		lk_d.rsync2 = lk_q.rsync1;
		if (lk_push)
		begin
			lk_d.mem[lk_q.wbin[PW-2:0]] = {link_packet_fault_i,
				link_packet_marker_i, link_byte_bus_i};
			lk_d.wbin  = lk_q.wbin + 1'b1;
			lk_d.wgray = pidma_pkg::bin2gray(lk_q.wbin + 1'b1);
		end
	end

	always_ff @(posedge link_byte_clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			lk_q <= '0;
		else
			lk_q <= lk_d;
	end

	// System domain. The entry under the read pointer is stable once the
	// synchronised gray write pointer shows it, so it is read directly.
	assign avail   = (sq.rgray != sq.wsync2);
	assign head    = lk_q.mem[sq.rbin[PW-2:0]];
	assign h_mark  = head[pidma_pkg::ENT_MARK_BIT];
	assign h_fault = head[pidma_pkg::ENT_FAULT_BIT];
	assign h_byte  = head[pidma_pkg::ENT_DATA_LSB +: 8];
	assign rising  = h_mark & ~sq.last_mark;

	always_comb
	begin
		nword = sq.word;
		nword[{sq.lane, 3'b000} +: 8] = h_byte;
		nbe = sq.be | (pidma_pkg::BE_LANE0 << sq.lane);
	end

	always_comb
	begin
		sd        = sq;
		sd.ack    = 1'b0;
		sd.wsync1 = lk_q.wgray;
		sd.wsync2 = sq.wsync1;
		pop       = 1'b0;
		take      = 1'b0;
		err       = 1'b0;
		push_v    = 1'b0;
		flush     = 1'b0;
		push_d    = {nbe, sq.addr, nword};
		unique case (sq.st)
			pidma_pkg::ST_IDLE:
			begin
				if (chan_req_i)
				begin
					sd.base = chan_addr_i;
					sd.addr = chan_addr_i;
					sd.len  = chan_len_i;
					sd.left = chan_len_i;
					sd.lane = '0;
					sd.be   = pidma_pkg::BE_NONE;
					sd.word = '0;
					// A marker already high at the head is not a fresh edge.
					sd.last_mark = 1'b1;
					sd.st = (chan_len_i == '0) ? pidma_pkg::ST_DRAIN
						: pidma_pkg::ST_HUNT;
				end
			end
			pidma_pkg::ST_HUNT:
			begin
				if (avail && wf.push_ready)
				begin
					pop  = 1'b1;
					take = rising & ~h_fault;
				end
			end
			pidma_pkg::ST_XFER:
			begin
				if (avail && wf.push_ready)
				begin
					pop = 1'b1;
					if (h_fault && h_mark)
						err = 1'b1;
					else
						take = 1'b1;
				end
			end
			pidma_pkg::ST_DRAIN:
			begin
				if (!wf.pop_valid)
				begin
					sd.ack = 1'b1;
					sd.st  = pidma_pkg::ST_IDLE;
				end
			end
			default:
				sd.st = pidma_pkg::ST_IDLE;
		endcase

		if (take)
		begin
			sd.st   = pidma_pkg::ST_XFER;
			sd.word = nword;
			sd.be   = nbe;
			sd.left = sq.left - 1'b1;
			sd.lane = sq.lane + 1'b1;
			if (sq.lane == pidma_pkg::LAST_LANE || sq.left == LEN_W'(1))
			begin
				push_v  = 1'b1;
				sd.addr = sq.addr + pidma_pkg::WORD_STEP;
				sd.lane = '0;
				sd.be   = pidma_pkg::BE_NONE;
				sd.word = '0;
			end
			if (sq.left == LEN_W'(1))
				sd.st = pidma_pkg::ST_DRAIN;
		end

		if (err)
		begin
			flush   = 1'b1;
			sd.addr = sq.base;
			sd.left = sq.len;
			sd.lane = '0;
			sd.be   = pidma_pkg::BE_NONE;
			sd.word = '0;
			sd.st   = pidma_pkg::ST_HUNT;
		end

		if (pop)
		begin
			sd.rbin      = sq.rbin + 1'b1;
			sd.rgray     = pidma_pkg::bin2gray(sq.rbin + 1'b1);
			sd.last_mark = h_mark;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sq      <= '0;
			sq.st   <= pidma_pkg::ST_IDLE;
		end
		else
			sq <= sd;
	end

	assign wf.push_valid = push_v;
	assign wf.push_data  = push_d;
	assign wf.flush      = flush;
	assign wf.pop_ready  = mem_ready_i;
	assign mem_valid_o   = wf.pop_valid;
	assign mem_be_o      = wf.pop_data[pidma_pkg::WF_W-1 -: pidma_pkg::BE_W];
	assign mem_addr_o    = wf.pop_data[pidma_pkg::DATA_W +: pidma_pkg::ADDR_W];
	assign mem_data_o    = wf.pop_data[pidma_pkg::DATA_W-1:0];
	assign chan_ack_o    = sq.ack;
	assign chan_busy_o   = (sq.st != pidma_pkg::ST_IDLE);

	sequence err_pop_s;
		sq.st == pidma_pkg::ST_XFER && pop && h_fault && h_mark;
	endsequence

	sequence restored_s;
		sq.st == pidma_pkg::ST_HUNT && sq.addr == sq.base &&
			sq.left == sq.len && !chan_ack_o;
	endsequence

	in_fifo_bound_a: assert property (@(posedge link_byte_clock_i)
		disable iff (!rst_n_i) lk_occ <= pidma_pkg::IN_DEPTH)
		else $error("Input FIFO holds more than its depth.");

	full_drop_a: assert property (@(posedge link_byte_clock_i)
		disable iff (!rst_n_i)
		link_byte_valid_i && lk_full |=> lk_q.wbin == $past(lk_q.wbin))
		else $error("Byte stored while input FIFO full.");

	req_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sq.st == pidma_pkg::ST_IDLE && chan_req_i |=>
			sq.base == $past(chan_addr_i) && sq.left == $past(chan_len_i))
		else $error("Channel input not loaded.");

	hunt_skip_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sq.st == pidma_pkg::ST_HUNT && pop && !rising |=>
			sq.st == pidma_pkg::ST_HUNT && sq.left == $past(sq.left))
		else $error("Transfer started without marker edge.");

	start_fault_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sq.st == pidma_pkg::ST_HUNT && pop && h_fault |=>
			sq.st == pidma_pkg::ST_HUNT)
		else $error("Packet started on faulty start byte.");

	err_restore_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		err_pop_s |=> restored_s ##1 !wf.pop_valid)
		else $error("Fault did not restore and discard.");

	fault_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sq.st == pidma_pkg::ST_XFER && pop && h_fault && !h_mark |=>
			sq.left == $past(sq.left) - LEN_W'(1))
		else $error("Fault honoured with marker low.");

	be_shape_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		push_v |-> nbe inside {4'h1, 4'h3, 4'h7, 4'hF} &&
			(nbe == 4'hF || sq.left == LEN_W'(1)))
		else $error("Partial word written before end of packet.");

	ack_empty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		chan_ack_o |-> !wf.pop_valid && $past(sq.st) == pidma_pkg::ST_DRAIN)
		else $error("Acknowledge with data still queued.");

	ack_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		chan_ack_o |=> !chan_ack_o)
		else $error("Acknowledge held longer than one cycle.");

	sequence hunt_start_s;
		sq.st == pidma_pkg::ST_HUNT && take;
	endsequence

	xfer_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hunt_start_s |=> sq.st != pidma_pkg::ST_HUNT &&
			sq.left == $past(sq.left) - LEN_W'(1))
		else $error("Start byte not forwarded.");

	word_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		push_v |=> sq.addr == $past(sq.addr) + pidma_pkg::WORD_STEP)
		else $error("Write address did not advance one word.");

	rgray_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$countones(sq.rgray ^ $past(sq.rgray)) <= 1)
		else $error("Read pointer moved more than one bit.");

	wgray_step_a: assert property (@(posedge link_byte_clock_i)
		disable iff (!rst_n_i)
		$countones(lk_q.wgray ^ $past(lk_q.wgray)) <= 1)
		else $error("Write pointer moved more than one bit.");

endmodule : pidma_top
`default_nettype wire

// *** core/pidma_wf_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pidma_wf_if #(
	parameter int unsigned W = 68
);
	logic         push_valid;
	logic         push_ready;
	logic [W-1:0] push_data;
	logic         pop_valid;
	logic         pop_ready;
	logic [W-1:0] pop_data;
	logic         flush;

	modport fifo_end (
		input  push_valid, push_data, pop_ready, flush,
		output push_ready, pop_valid, pop_data
	);
	modport user_end (
		output push_valid, push_data, pop_ready, flush,
		input  push_ready, pop_valid, pop_data
	);
endinterface : pidma_wf_if
`default_nettype wire

// *** core/pidma_word_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module pidma_word_fifo #(
	parameter int unsigned W     = 68,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic     clk_i,
	input  wire logic     rst_n_i,
	pidma_wf_if.fifo_end  wf
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           rd;
		logic [AW-1:0]           wr;
		logic [AW:0]             cnt;
	} pidma_wf_s;

	pidma_wf_s q;
	pidma_wf_s d;
	logic      do_push;
	logic      do_pop;

	assign wf.push_ready = (q.cnt != DEPTH[AW:0]);
	assign wf.pop_valid  = (q.cnt != '0);
	assign wf.pop_data   = q.mem[q.rd];
	assign do_push       = wf.push_valid & wf.push_ready;
	assign do_pop        = wf.pop_valid & wf.pop_ready;

	always_comb
	begin
		d = q;
		if (wf.flush)
		begin
			// A discarded packet takes every queued word with it.
			d.rd  = '0;
			d.wr  = '0;
			d.cnt = '0;
		end
		else
		begin
			if (do_push)
			begin
				d.mem[q.wr] = wf.push_data;
				d.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
			end
			if (do_pop)
				d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
			d.cnt = q.cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q <= '0;
		else
			q <= d;
	end

	wf_count_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.cnt <= DEPTH[AW:0])
		else $error("Word FIFO count exceeds its depth.");

endmodule : pidma_word_fifo
`default_nettype wire

// *** dv/pidma_link_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pidma_link_model (
	output var logic       link_byte_clock_o,
	output var logic       link_byte_valid_o,
	output var logic [7:0] link_byte_bus_o,
	output var logic       link_packet_fault_o,
	output var logic       link_packet_marker_o
);
	initial
	begin
		link_byte_clock_o = 1'b0;
		link_byte_valid_o = 1'b0;
		link_byte_bus_o = 8'h00;
		link_packet_fault_o = 1'b0;
		link_packet_marker_o = 1'b0;
	end

	// The byte clock runs free, so the pointer synchronisers keep moving
	// while no byte is offered.
	always #32 link_byte_clock_o = ~link_byte_clock_o;

	// A byte is set up on the falling edge and taken on the rising one.
	// Just after it the bus shows the inverse so stale data cannot look
	// valid.
	task automatic put(input logic [7:0] d, input logic mk, input logic ft);
		@(negedge link_byte_clock_o);
		link_byte_valid_o = 1'b1;
		link_byte_bus_o = d;
		link_packet_marker_o = mk;
		link_packet_fault_o = ft;
		@(posedge link_byte_clock_o);
		#2 link_byte_valid_o = 1'b0;
		link_byte_bus_o = ~d;
		link_packet_fault_o = 1'b0;
	endtask : put
endmodule : pidma_link_model
`default_nettype wire

// *** dv/pidma_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pidma_top_tb;
	typedef struct {
		logic [31:0] addr;
		logic [15:0] len;
		logic [7:0]  first;
		logic        stall;
	} pidma_row_s;

	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        chan_req_i = 1'b0;
	logic [31:0] chan_addr_i = 32'h0;
	logic [15:0] chan_len_i = 16'h0;
	logic        mem_ready_i = 1'b1;
	logic        stall = 1'b0;
	wire logic   lclk;
	wire logic   lval;
	wire logic   lfault;
	wire logic   lmark;
	wire logic [7:0] lbus;
	logic        chan_ack_o;
	logic        chan_busy_o;
	logic        mem_valid_o;
	logic [31:0] mem_addr_o;
	logic [31:0] mem_data_o;
	logic [3:0]  mem_be_o;
	logic [7:0]  mem [logic [31:0]];
	int          n_fail = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          n_ack = 0;
	int          ack_mark = 0;
	pidma_row_s  rows [7] = '{
		'{32'h0000_1000, 16'h0000, 8'h10, 1'b0},
		'{32'h0000_1100, 16'h0001, 8'h11, 1'b0},
		'{32'h0000_2000, 16'h0003, 8'h20, 1'b1},
		'{32'h0000_3000, 16'h0004, 8'h30, 1'b0},
		'{32'h0000_4000, 16'h0005, 8'h40, 1'b1},
		'{32'h0000_5000, 16'h0008, 8'h50, 1'b0},
		'{32'h0000_6000, 16'h000D, 8'h60, 1'b1}};

	pidma_link_model lm (
		.link_byte_clock_o    (lclk),
		.link_byte_valid_o    (lval),
		.link_byte_bus_o      (lbus),
		.link_packet_fault_o  (lfault),
		.link_packet_marker_o (lmark)
	);

	pidma_top dut (
		.clk_i              (clk_i),
		.rst_n_i            (rst_n_i),
		.link_byte_clock_i  (lclk),
		.link_byte_valid_i  (lval),
		.link_byte_bus_i    (lbus),
		.link_packet_fault_i (lfault),
		.link_packet_marker_i (lmark),
		.chan_req_i         (chan_req_i),
		.chan_addr_i        (chan_addr_i),
		.chan_len_i         (chan_len_i),
		.chan_ack_o         (chan_ack_o),
		.chan_busy_o        (chan_busy_o),
		.mem_valid_o        (mem_valid_o),
		.mem_ready_i        (mem_ready_i),
		.mem_addr_o         (mem_addr_o),
		.mem_data_o         (mem_data_o),
		.mem_be_o           (mem_be_o)
	);

	always #12.5 clk_i = ~clk_i;

	// Memory model: stores each enabled lane, stalls every other pair.
	// It also counts acknowledge pulses, so none is missed while a task
	// is busy feeding the link.
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (chan_ack_o === 1'b1)
			n_ack <= n_ack + 1;
		mem_ready_i <= !stall || cyc[1];
		if (mem_valid_o === 1'b1 && mem_ready_i === 1'b1)
			for (int b = 0; b < 4; b++)
				if (mem_be_o[b])
					mem[mem_addr_o + 32'(b)] = mem_data_o[8*b +: 8];
	end

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic request(input logic [31:0] a, input logic [15:0] n);
		mem.delete();
		ack_mark = n_ack;
		@(posedge clk_i);
		chan_req_i <= 1'b1;
		chan_addr_i <= a;
		chan_len_i <= n;
		@(posedge clk_i);
		chan_req_i <= 1'b0;
		#1;
		chk("busy", 32'h1, {31'h0, chan_busy_o});
	endtask : request

	// A marker-low lead byte, then n marker-high bytes; fault at index f.
	task automatic pkt(input int n, input logic [7:0] s, input int f);
		lm.put(8'h5A, 1'b0, 1'b0);
		for (int i = 0; i < n; i++)
			lm.put(s + 8'(i), 1'b1, i == f);
	endtask : pkt

	// Bytes 0..k-1 expected from s, the rest from s2.
	task automatic verify(input logic [31:0] a, input int n,
		input logic [7:0] s, input int k, input logic [7:0] s2);
		logic [7:0] e;
		for (int t = 0; t < 4000 && n_ack == ack_mark; t++)
		begin
			@(posedge clk_i);
			#1;
		end
		chk("ack", 32'h1, 32'(n_ack - ack_mark));
		chk("ack_low", 32'h0, {31'h0, chan_ack_o});
		chk("busy", 32'h0, {31'h0, chan_busy_o});
		chk("count", 32'(n), 32'(mem.size()));
		for (int i = 0; i < n; i++)
		begin
			e = (i < k) ? s + 8'(i) : s2 + 8'(i - k);
			chk("byte", {24'h0, e}, {24'h0, mem[a + 32'(i)]});
		end
	endtask : verify

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#100us;
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("valid", 32'h0, {31'h0, mem_valid_o});
		chk("ack", 32'h0, {31'h0, chan_ack_o});
		foreach (rows[r])
		begin
			stall <= rows[r].stall;
			request(rows[r].addr, rows[r].len);
			pkt(int'(rows[r].len), rows[r].first, -1);
			verify(rows[r].addr, int'(rows[r].len), rows[r].first,
				int'(rows[r].len), 8'h00);
		end
		// Fault on the start byte, then a fault with the marker low.
		request(32'h0000_8000, 16'h0004);
		lm.put(8'h5A, 1'b0, 1'b0);
		lm.put(8'hBB, 1'b1, 1'b1);
		lm.put(8'hBC, 1'b1, 1'b0);
		lm.put(8'h5A, 1'b0, 1'b0);
		lm.put(8'h80, 1'b1, 1'b0);
		lm.put(8'h81, 1'b0, 1'b1);
		lm.put(8'h82, 1'b0, 1'b0);
		lm.put(8'h83, 1'b0, 1'b0);
		verify(32'h0000_8000, 4, 8'h80, 4, 8'h00);
		// The last byte taken had its marker low, so only the forced
		// marker state keeps a marker already high at the head from
		// starting a transfer.
		lm.put(8'hEE, 1'b1, 1'b0);
		lm.put(8'hEF, 1'b1, 1'b0);
		request(32'h0000_7000, 16'h0004);
		pkt(4, 8'h70, -1);
		verify(32'h0000_7000, 4, 8'h70, 4, 8'h00);
		// Fault in mid-packet: restart at base with the next packet.
		stall <= 1'b1;
		request(32'h0000_A000, 16'h0008);
		pkt(8, 8'hA0, 5);
		pkt(8, 8'hC0, -1);
		verify(32'h0000_A000, 8, 8'hC0, 8, 8'h00);
		// Overfill while idle: only the first 24 bytes are kept.
		stall <= 1'b0;
		for (int i = 0; i < 30; i++)
			lm.put(8'(i), i != 0, 1'b0);
		repeat (10) @(posedge clk_i);
		request(32'h0000_B000, 16'h001A);
		// Let the port drain the full FIFO before more bytes arrive.
		repeat (40) @(posedge clk_i);
		for (int i = 0; i < 3; i++)
			lm.put(8'hA0 + 8'(i), 1'b1, 1'b0);
		verify(32'h0000_B000, 26, 8'h01, 23, 8'hA0);
		// Reset in mid-transfer returns both domains to idle.
		request(32'h0000_C000, 16'h0004);
		pkt(1, 8'hD0, -1);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		chk("busy", 32'h0, {31'h0, chan_busy_o});
		chk("valid", 32'h0, {31'h0, mem_valid_o});
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("busy", 32'h0, {31'h0, chan_busy_o});
		chk("count", 32'h0, 32'(mem.size()));
		request(32'h0000_D000, 16'h0002);
		pkt(2, 8'hE0, -1);
		verify(32'h0000_D000, 2, 8'hE0, 2, 8'h00);
		tally_and_finish();
	end
endmodule : pidma_top_tb
`default_nettype wire
